// file: core/rtc_ctrl_regs.svh
// Register map and field constants of the RTC control block
`ifndef RTC_CTRL_REGS_SVH
`define RTC_CTRL_REGS_SVH
// ----------------------------------------
// Offsets
// ----------------------------------------
`define OFS_CTRL_A     8'h0a
`define OFS_CTRL_B     8'h0b
`define OFS_FLAGS      8'h0c
`define OFS_VALID      8'h0d
`define OFS_DOM_A1     8'h0e
// ----------------------------------------
// Fields
// ----------------------------------------
`define B_FREEZE       7
`define B_PIE          6
`define B_ALARM_ONE_IRQ_ENABLE         5
`define B_UPDATE_DONE_IRQ_ENABLE         4
`define B_ALARM_TWO_IRQ_ENABLE         3
`define B_NUMFMT       2
`define B_HRFMT        1
`define B_DST          0
`define B_SUMMARY_IRQ_FLAG         7
`define B_PF           6
`define B_A1F          5
`define B_UF           4
`define B_A2F          3
`define B_VALID        7
`define RATE_W         4
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define RST_BYTE       8'h00
`define RST_DOM_A1     8'hc0
`define DONT_CARE      2'h3
`define RATE_OFF       4'h0
`define RATE_ALIAS_LO  4'h1
`define RATE_ALIAS_HI  4'h2
`define TAP_ALIAS_LO   4'h7
`define TAP_ALIAS_HI   4'h8
`define TAP_MIN        15
`define SUNDAY         8'h01
`define APRIL          8'h04
`define OCT_BCD        8'h10
`define OCT_BIN        8'h0a
`define FIRST_WK_END   8'h07
`define LAST_WK_BCD    8'h25
`define LAST_WK_BIN    8'h19
`define DOM_MIN        8'h01
`define DOM_MAX_BCD    8'h31
`define DOM_MAX_BIN    8'h1f
`define HR_ONE         8'h01
`define HR_THREE       8'h03
`define MS_LAST_BCD    8'h59
`define MS_LAST_BIN    8'h3b
`endif

// file: core/rtc_ctrl_pkg.sv
// Types shared by the RTC control block
package rtc_ctrl_pkg;
    // ----------------------------------------
    // Current time from the counters
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] month;
        logic [7:0] dom;
        logic [7:0] dow;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } rtc_time_s;
    // ----------------------------------------
    // Hour reload command
    // ----------------------------------------
    typedef struct packed {
        logic       load;
        logic [7:0] hour;
    } hour_load_s;
    // ----------------------------------------
    // Fall-back tracking
    // ----------------------------------------
    typedef enum logic [0:0] {
        FALL_ARMED = 1'b0,
        FALL_DONE  = 1'b1
    } fall_state_e;
endpackage : rtc_ctrl_pkg

// file: core/rtc_control_status_alarm.sv
// RTC control, status, flags and date alarm 1
//
// The implementer's own choice: the address-and-strobe port.
`include "rtc_ctrl_regs.svh"
module rtc_control_status_alarm #(
    parameter int TAP_W = 15
) (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    // Register port
    input  wire logic [7:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [7:0]              reg_rdata,
    // RTC state
    input  wire logic                    rtc_enable,
    input  wire logic                    supply_ok,
    input  wire logic [TAP_W-1:0]        div_taps,
    input  wire logic                    update_tick,
    input  wire rtc_ctrl_pkg::rtc_time_s cur_time,
    input  wire logic                    alarm_one_time_match,
    input  wire logic                    alarm_two_match,
    // Time counter control
    output logic                         time_update,
    output rtc_ctrl_pkg::hour_load_s     hour_load,
    output logic                         number_format_select,
    output logic                         hour_format_select,
    // Interrupt
    output logic                         irq
);
    import rtc_ctrl_pkg::*;

    if (TAP_W < `TAP_MIN) begin : g_tap_check
        $error("TAP_W too small");
    end

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [3:0] tap_of(input logic [3:0] rs);
        logic [3:0] t;
        t = rs - 4'h1;
        if (rs == `RATE_OFF) begin
            t = 4'h0;
        end else if (rs == `RATE_ALIAS_LO) begin
            t = `TAP_ALIAS_LO;
        end else if (rs == `RATE_ALIAS_HI) begin
            t = `TAP_ALIAS_HI;
        end
        return t;
    endfunction : tap_of

    function automatic logic is_last(input logic [7:0] v,
                                     input logic       bin);
        return v == (bin ? `MS_LAST_BIN : `MS_LAST_BCD);
    endfunction : is_last

    function automatic logic dom_ok(input logic [7:0] v,
                                    input logic       bin);
        logic [7:0] hi;
        hi = bin ? `DOM_MAX_BIN : `DOM_MAX_BCD;
        return (v[7:6] == `DONT_CARE) || (v >= `DOM_MIN && v <= hi);
    endfunction : dom_ok

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [3:0]  rate_reg;
    logic [7:0]  ctrl_b_reg;
    logic [7:0]  ctrl_b_next;
    logic        summary_irq_flag_reg;
    logic        summary_irq_flag_next;
    logic        pf_reg;
    logic        pf_next;
    logic        a1f_reg;
    logic        a1f_next;
    logic        uf_reg;
    logic        uf_next;
    logic        a2f_reg;
    logic        a2f_next;
    logic        valid_reg;
    logic [7:0]  dom_a1_reg;
    logic        tap_prev_reg;
    logic        upd_reg;
    logic [7:0]  rdata_reg;
    hour_load_s  hload_reg;
    fall_state_e fall_reg;
    fall_state_e fall_next;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire wr_a    = reg_wr && (reg_addr == `OFS_CTRL_A);
    wire wr_b    = reg_wr && (reg_addr == `OFS_CTRL_B);
    wire wr_dom  = reg_wr && (reg_addr == `OFS_DOM_A1);
    wire rd_flag = reg_rd && (reg_addr == `OFS_FLAGS);
    wire off     = !rtc_enable;
    wire bin     = ctrl_b_reg[`B_NUMFMT];
    wire periodic_irq_enable     = ctrl_b_reg[`B_PIE];
    wire alarm_one_irq_enable    = ctrl_b_reg[`B_ALARM_ONE_IRQ_ENABLE];
    wire update_done_irq_enable    = ctrl_b_reg[`B_UPDATE_DONE_IRQ_ENABLE];

    // ----------------------------------------
    // Periodic tick
    // ----------------------------------------
    wire [3:0] tap_idx = tap_of(rate_reg);
    wire       tap_sel = div_taps[tap_idx];
    wire       p_tick  = (rate_reg != `RATE_OFF)
                         && tap_sel && !tap_prev_reg;

    // ----------------------------------------
    // Update and daylight saving
    // ----------------------------------------
    wire upd_go   = update_tick && !ctrl_b_reg[`B_FREEZE];
    wire sunday   = cur_time.dow == `SUNDAY;
    wire hr_one   = cur_time.hour == `HR_ONE;
    wire t_last   = hr_one && is_last(cur_time.min, bin)
                    && is_last(cur_time.sec, bin);
    wire oct      = cur_time.month == (bin ? `OCT_BIN : `OCT_BCD);
    wire spring   = sunday && cur_time.month == `APRIL
                    && cur_time.dom <= `FIRST_WK_END;
    wire fall_day = sunday && oct
                    && cur_time.dom >= (bin ? `LAST_WK_BIN : `LAST_WK_BCD);
    wire dst_on   = ctrl_b_reg[`B_DST];
    wire go_fwd   = dst_on && upd_go && spring && t_last;
    wire go_back  = dst_on && upd_go && fall_day && t_last
                    && fall_reg == FALL_ARMED;

    always_comb begin
        fall_next = fall_reg;
        if (go_back) begin
            fall_next = FALL_DONE;
        end else if (!fall_day) begin
            fall_next = FALL_ARMED;
        end
    end

    // ----------------------------------------
    // Alarm matching
    // ----------------------------------------
    wire dom_any = dom_a1_reg[7:6] == `DONT_CARE;
    wire dom_hit = dom_any || dom_a1_reg == cur_time.dom;
    wire a1_hit  = upd_go && alarm_one_time_match && dom_hit;
    wire a2_hit  = upd_go && alarm_two_match;
    wire dom_wok = dom_ok(reg_wdata, bin);

    // ----------------------------------------
    // Control B next value
    // ----------------------------------------
    always_comb begin
        ctrl_b_next = wr_b ? reg_wdata : ctrl_b_reg;
        if (off) begin
            ctrl_b_next[`B_PIE]  = 1'b0;
            ctrl_b_next[`B_UPDATE_DONE_IRQ_ENABLE] = 1'b0;
        end
        if (!valid_reg) begin
            ctrl_b_next[`B_ALARM_ONE_IRQ_ENABLE] = 1'b0;
            ctrl_b_next[`B_ALARM_TWO_IRQ_ENABLE] = 1'b0;
        end
    end

    // ----------------------------------------
    // Flag next values, set wins over read clear except for the summary flag, which the read clears
    // ----------------------------------------
    wire irq_cond = (pf_reg && periodic_irq_enable) || (a1f_reg && alarm_one_irq_enable)
                    || (uf_reg && update_done_irq_enable);

    always_comb begin
        pf_next   = p_tick || (pf_reg && !rd_flag);
        uf_next   = upd_reg || (uf_reg && !rd_flag);
        a1f_next  = a1_hit || (a1f_reg && !rd_flag);
        a2f_next  = a2_hit || (a2f_reg && !rd_flag);
        summary_irq_flag_next = !rd_flag && (irq_cond || summary_irq_flag_reg);
        if (off) begin
            pf_next   = 1'b0;
            uf_next   = 1'b0;
            summary_irq_flag_next = 1'b0;
        end
        if (!valid_reg) begin
            a1f_next = 1'b0;
            a2f_next = 1'b0;
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    wire [7:0] flags_rd = {summary_irq_flag_reg, pf_reg, a1f_reg,
                           uf_reg, a2f_reg, 3'h0};
    wire [7:0] valid_rd = {valid_reg, 7'h00};
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = `RST_BYTE;
        if (reg_addr == `OFS_CTRL_A) begin
            rd_mux = {4'h0, rate_reg};
        end else if (reg_addr == `OFS_CTRL_B) begin
            rd_mux = ctrl_b_reg;
        end else if (reg_addr == `OFS_FLAGS) begin
            rd_mux = flags_rd;
        end else if (reg_addr == `OFS_VALID) begin
            rd_mux = valid_rd;
        end else if (reg_addr == `OFS_DOM_A1) begin
            rd_mux = dom_a1_reg;
        end
    end

    // ----------------------------------------
    // Flip-flops
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rate_reg   <= `RATE_OFF;
            ctrl_b_reg <= `RST_BYTE;
            dom_a1_reg <= `RST_DOM_A1;
        end else begin
            if (wr_a) begin
                rate_reg <= reg_wdata[`RATE_W-1:0];
            end
            ctrl_b_reg <= ctrl_b_next;
            if (wr_dom && dom_wok) begin
                dom_a1_reg <= reg_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            summary_irq_flag_reg <= 1'b0;
            pf_reg   <= 1'b0;
            a1f_reg  <= 1'b0;
            uf_reg   <= 1'b0;
            a2f_reg  <= 1'b0;
        end else begin
            summary_irq_flag_reg <= summary_irq_flag_next;
            pf_reg   <= pf_next;
            a1f_reg  <= a1f_next;
            uf_reg   <= uf_next;
            a2f_reg  <= a2f_next;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            valid_reg    <= 1'b0;
            tap_prev_reg <= 1'b0;
            upd_reg      <= 1'b0;
            fall_reg     <= FALL_ARMED;
        end else begin
            valid_reg    <= supply_ok;
            tap_prev_reg <= tap_sel;
            upd_reg      <= upd_go;
            fall_reg     <= fall_next;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= `RST_BYTE;
            hload_reg <= '0;
        end else begin
            rdata_reg      <= reg_rd ? rd_mux : `RST_BYTE;
            hload_reg.load <= go_fwd || go_back;
            hload_reg.hour <= go_fwd ? `HR_THREE : `HR_ONE;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata            = rdata_reg;
    assign time_update          = upd_go;
    assign hour_load            = hload_reg;
    assign number_format_select = ctrl_b_reg[`B_NUMFMT];
    assign hour_format_select   = ctrl_b_reg[`B_HRFMT];
    assign irq                  = summary_irq_flag_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_freeze;
        ctrl_b_reg[`B_FREEZE] |-> !time_update ##1 !upd_reg;
    endproperty
    a_freeze: assert property (p_freeze) else $error("update while frozen");

    property p_en_off;
        !rtc_enable |=> !ctrl_b_reg[`B_PIE] && !ctrl_b_reg[`B_UPDATE_DONE_IRQ_ENABLE];
    endproperty
    a_en_off: assert property (p_en_off) else $error("enable kept while off");

    property p_alarm_en;
        !valid_reg |=> !ctrl_b_reg[`B_ALARM_ONE_IRQ_ENABLE] && !ctrl_b_reg[`B_ALARM_TWO_IRQ_ENABLE];
    endproperty
    a_alarm_en: assert property (p_alarm_en) else $error("alarm enable kept");

    property p_uf_set;
        update_tick && !ctrl_b_reg[`B_FREEZE] && rtc_enable ##1 rtc_enable
        |=> uf_reg;
    endproperty
    a_uf_set: assert property (p_uf_set) else $error("update flag missed");

    property p_summary;
        pf_reg && ctrl_b_reg[`B_PIE] && rtc_enable && !rd_flag |=> irq;
    endproperty
    a_summary: assert property (p_summary) else $error("summary not set");

    property p_rd_clr;
        rd_flag && !p_tick && !upd_reg && !a1_hit && !a2_hit
        |=> !pf_reg && !uf_reg && !a1f_reg && !a2f_reg && !summary_irq_flag_reg;
    endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("flags not cleared");

    property p_rate0;
        rate_reg == `RATE_OFF && !pf_reg |=> !pf_reg;
    endproperty
    a_rate0: assert property (p_rate0) else $error("periodic flag at rate 0");

    property p_valid_rd;
        reg_rd && reg_addr == `OFS_VALID |=> reg_rdata == {$past(valid_reg), 7'h00};
    endproperty
    a_valid_rd: assert property (p_valid_rd) else $error("valid reads wrong");

    property p_fwd;
        go_fwd |=> hour_load.load && hour_load.hour == `HR_THREE;
    endproperty
    a_fwd: assert property (p_fwd) else $error("spring step wrong");

    property p_back_once;
        go_back |=> fall_reg == FALL_DONE ##0 !go_back;
    endproperty
    a_back_once: assert property (p_back_once) else $error("fall step twice");

    property p_dom_rst;
        $rose(!sys_rst) |-> dom_a1_reg == `RST_DOM_A1;
    endproperty
    a_dom_rst: assert property (p_dom_rst) else $error("date alarm reset wrong");

    property p_dc_match;
        dom_a1_reg[7:6] == `DONT_CARE && valid_reg && alarm_one_time_match
        && update_tick && !ctrl_b_reg[`B_FREEZE] |=> a1f_reg;
    endproperty
    a_dc_match: assert property (p_dc_match) else $error("don't-care missed");

    property p_a_inv;
        !valid_reg |=> !a1f_reg && !a2f_reg;
    endproperty
    a_a_inv: assert property (p_a_inv) else $error("alarm flag while invalid");

    property p_rsv;
        reg_rd && reg_addr == `OFS_FLAGS |=> reg_rdata[2:0] == 3'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule : rtc_control_status_alarm

// file: testbench/rtc_control_status_alarm_tb_top.sv
// Self-checking testbench of the RTC control, status and date alarm block
`include "rtc_ctrl_regs.svh"
module rtc_control_status_alarm_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import rtc_ctrl_pkg::*;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic             ref_clk;
    logic             sys_rst;
    logic [7:0]       reg_addr;
    logic [7:0]       reg_wdata;
    logic             reg_wr;
    logic             reg_rd;
    logic [7:0]       reg_rdata;
    logic             rtc_enable;
    logic             supply_ok;
    logic [14:0]      div_taps;
    logic             update_tick;
    rtc_time_s        cur_time;
    logic             alarm_one_time_match;
    logic             alarm_two_match;
    logic             time_update;
    hour_load_s       hour_load;
    logic             number_format_select;
    logic             hour_format_select;
    logic             irq;
    int               failures;
    int               samples_checked;
    int               seed;
    logic [7:0]       loads[$];

    rtc_control_status_alarm #(.TAP_W(15)) dut_u (
        .ref_clk              (ref_clk),
        .sys_rst              (sys_rst),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_rdata            (reg_rdata),
        .rtc_enable           (rtc_enable),
        .supply_ok            (supply_ok),
        .div_taps             (div_taps),
        .update_tick          (update_tick),
        .cur_time             (cur_time),
        .alarm_one_time_match (alarm_one_time_match),
        .alarm_two_match      (alarm_two_match),
        .time_update          (time_update),
        .hour_load            (hour_load),
        .number_format_select (number_format_select),
        .hour_format_select   (hour_format_select),
        .irq                  (irq)
    );

    // ----------------------------------------
    // Clock and hour reload capture
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    always @(negedge ref_clk) begin
        if (hour_load.load === 1'b1) begin
            loads.push_back(hour_load.hour);
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd_chk

    task automatic tick(input logic exp_tu);
        @(posedge ref_clk);
        update_tick <= 1'b1;
        #1;
        chk({7'h00, time_update}, {7'h00, exp_tu});
        @(posedge ref_clk);
        update_tick <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : tick

    task automatic final_report;
        if (failures == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        $display("Error at %0t: run timed out", $time);
        final_report();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] v;
        logic [7:0] m_dom;
        logic [7:0] dv [8];
        int         tap;
        dv = '{8'h00, 8'h31, 8'h32, 8'h01, 8'h20, 8'h1f, 8'h25, 8'hc7};
        failures = 0;
        samples_checked = 0;
        seed = 32'hec82;
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rtc_enable = 1'b1;
        supply_ok = 1'b0;
        div_taps = 15'h0000;
        update_tick = 1'b0;
        cur_time = '0;
        alarm_one_time_match = 1'b0;
        alarm_two_match = 1'b0;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // Reset values and unmapped place
        rd_chk(`OFS_CTRL_B, `RST_BYTE);
        rd_chk(`OFS_FLAGS, 8'h00);
        rd_chk(`OFS_VALID, 8'h00);
        rd_chk(`OFS_DOM_A1, `RST_DOM_A1);
        rd_chk(8'h20, 8'h00);
        // Alarm enables refused while contents invalid
        wr(`OFS_CTRL_B, 8'h28);
        rd_chk(`OFS_CTRL_B, 8'h00);
        supply_ok <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rd_chk(`OFS_VALID, 8'h80);
        wr(`OFS_VALID, 8'hff);
        wr(`OFS_FLAGS, 8'hff);
        rd_chk(`OFS_VALID, 8'h80);
        rd_chk(`OFS_FLAGS, 8'h00);
        // Random control values and format selects
        for (int i = 0; i < 8; i++) begin
            v = 8'($random(seed));
            wr(`OFS_CTRL_B, v);
            rd_chk(`OFS_CTRL_B, v);
            chk({7'h00, number_format_select}, {7'h00, v[2]});
            chk({7'h00, hour_format_select}, {7'h00, v[1]});
        end
        // Disable and invalid contents clear enables
        wr(`OFS_CTRL_B, 8'h78);
        rtc_enable <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rd_chk(`OFS_CTRL_B, 8'h28);
        rtc_enable <= 1'b1;
        wr(`OFS_CTRL_B, 8'h78);
        supply_ok <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd_chk(`OFS_CTRL_B, 8'h50);
        supply_ok <= 1'b1;
        repeat (2) @(posedge ref_clk);
        // Freeze blocks updates
        wr(`OFS_CTRL_B, 8'h90);
        tick(1'b0);
        rd_chk(`OFS_FLAGS, 8'h00);
        // Update ended flag, summary and read clear
        wr(`OFS_CTRL_B, 8'h10);
        tick(1'b1);
        chk({7'h00, irq}, 8'h01);
        rd_chk(`OFS_FLAGS, 8'h90);
        rd_chk(`OFS_FLAGS, 8'h00);
        chk({7'h00, irq}, 8'h00);
        wr(`OFS_CTRL_B, 8'h00);
        tick(1'b1);
        rd_chk(`OFS_FLAGS, 8'h10);
        wr(`OFS_CTRL_B, 8'h10);
        tick(1'b1);
        rtc_enable <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rd_chk(`OFS_FLAGS, 8'h00);
        rtc_enable <= 1'b1;
        // Alarms with date compare
        alarm_one_time_match <= 1'b1;
        wr(`OFS_CTRL_B, 8'h28);
        wr(`OFS_DOM_A1, 8'h15);
        cur_time.dom <= 8'h14;
        tick(1'b1);
        rd_chk(`OFS_FLAGS, 8'h10);
        cur_time.dom <= 8'h15;
        tick(1'b1);
        rd_chk(`OFS_FLAGS, 8'hb0);
        alarm_one_time_match <= 1'b0;
        alarm_two_match <= 1'b1;
        tick(1'b1);
        rd_chk(`OFS_FLAGS, 8'h18);
        tick(1'b1);
        alarm_two_match <= 1'b0;
        supply_ok <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd_chk(`OFS_FLAGS, 8'h10);
        supply_ok <= 1'b1;
        repeat (2) @(posedge ref_clk);
        // Date alarm range per number format
        m_dom = 8'h15;
        for (int i = 0; i < 8; i++) begin
            wr(`OFS_CTRL_B, (i >= 4) ? 8'h04 : 8'h00);
            wr(`OFS_DOM_A1, dv[i]);
            if (dv[i][7:6] == 2'h3 || (dv[i] >= 8'h01 && dv[i] <= ((i >= 4) ? 8'h1f : 8'h31))) begin
                m_dom = dv[i];
            end
            rd_chk(`OFS_DOM_A1, m_dom);
        end
        // Don't-care date always matches
        alarm_one_time_match <= 1'b1;
        tick(1'b1);
        rd_chk(`OFS_FLAGS, 8'h30);
        alarm_one_time_match <= 1'b0;
        // Periodic rate codes and taps
        wr(`OFS_CTRL_B, 8'h40);
        for (int code = 0; code < 16; code++) begin
            div_taps <= 15'h0000;
            v = 8'($random(seed));
            wr(`OFS_CTRL_A, {v[7:4], 4'(code)});
            rd_chk(`OFS_CTRL_A, {4'h0, 4'(code)});
            rd_chk(`OFS_FLAGS, 8'h00);
            tap = (code == 1) ? 7 : (code == 2) ? 8 : code - 1;
            div_taps <= (code == 0) ? 15'h7fff : ~(15'h0001 << tap);
            repeat (3) @(posedge ref_clk);
            rd_chk(`OFS_FLAGS, 8'h00);
            div_taps <= 15'h7fff;
            repeat (3) @(posedge ref_clk);
            chk({7'h00, irq}, (code != 0) ? 8'h01 : 8'h00);
            rd_chk(`OFS_FLAGS, (code != 0) ? 8'hc0 : 8'h00);
        end
        div_taps <= 15'h0000;
        wr(`OFS_CTRL_A, 8'h00);
        // Daylight saving steps
        cur_time <= '{month: 8'h04, dom: 8'h01, dow: 8'h01, hour: 8'h01, min: 8'h59, sec: 8'h59};
        wr(`OFS_CTRL_B, 8'h01);
        loads.delete();
        tick(1'b1);
        chk(8'(loads.size()), 8'h01);
        chk(loads[0], `HR_THREE);
        cur_time.month <= 8'h10;
        cur_time.dom <= 8'h25;
        loads.delete();
        tick(1'b1);
        chk(8'(loads.size()), 8'h01);
        chk(loads[0], `HR_ONE);
        loads.delete();
        tick(1'b1);
        chk(8'(loads.size()), 8'h00);
        wr(`OFS_CTRL_B, 8'h00);
        cur_time.month <= 8'h04;
        cur_time.dom <= 8'h01;
        loads.delete();
        tick(1'b1);
        chk(8'(loads.size()), 8'h00);
        // Fall step in binary format
        wr(`OFS_CTRL_B, 8'h05);
        cur_time <= '{month: 8'h0a, dom: 8'h19, dow: 8'h01, hour: 8'h01, min: 8'h3b, sec: 8'h3b};
        loads.delete();
        tick(1'b1);
        chk(8'(loads.size()), 8'h01);
        chk(loads[0], `HR_ONE);
        final_report();
    end
endmodule : rtc_control_status_alarm_tb_top
